// ---- src/pdv_map.vh ----
/*
  constants for the data-enable-only video input block: screen size,
  frame-start gap, pixel field layout and timing limits.
  assumes it is included by bare name from the design files.
*/
`ifndef PDV_MAP_VH
`define PDV_MAP_VH
// screen geometry
`define PDV_SCREEN_COLS 1920
`define PDV_SCREEN_ROWS 480
`define PDV_COL_W 11
`define PDV_ROW_W 10
// frame start needs a low gap of this many line periods
`define PDV_FRAME_GAP_LINES 8
// line period limits in pixel strobes, used to size the gap counter
`define PDV_LINE_MAX_STROBES 1325
`define PDV_LINE_MIN_STROBES 1030
`define PDV_GAP_CNT_W 14
// pixel word layout: red, green, blue, each bit 9 down to 0
`define PDV_PRIM_W 10
`define PDV_PIX_W 30
`define PDV_RED_MSB 29
`define PDV_RED_LSB 20
`define PDV_GRN_MSB 19
`define PDV_GRN_LSB 10
`define PDV_BLU_MSB 9
`define PDV_BLU_LSB 0
`define PDV_BLACK 30'h00000000
// lane format strap: high or open is the primary arrangement
`define PDV_FMT_PRIMARY 1'b1
// depth strap: high selects 10 bit, low or open 8 bit
`define PDV_DEPTH_10BIT 1'b1
`endif

// ---- src/pdv_sync2.v ----
/*
  two flip-flop level synchroniser, parameterised width.
  assumes the input is a level from another clock domain.
*/
`default_nettype none
module pdv_sync2 #(
  parameter W = 1
) (
  input wire sys_clk_i, // sampling clock
  input wire resetn_i, // async reset, active low
  input wire [W-1:0] async_i, // level from outside the domain
  output reg [W-1:0] sync_o // level safe to read
);
  reg [W-1:0] meta; // first stage, read only by second stage

  // two stages; first stage feeds nothing but the second
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // pdv_sync2
`default_nettype wire

// ---- src/pdv_video_in.v ----
/*
  data-enable-only video input: places pixels on the screen grid from
  the pixel_valid_window edges alone, fills short windows with black.
  assumes pixel_strobe, window, pixel and straps come from the source's
  domain and are sampled by sys_clk_i, which runs well above the strobe.
*/
//
// Function
// - first strobe after window rise is leftmost
// - rise after eight-line gap starts frame, top row
// - pixels outside short window shown as black
// - each primary is 10 bit brightness code
// - pixel word red, green, blue, bit 9 first
// - format strap high or open picks primary arrangement
// - depth strap high picks 10 bit, else 8
`default_nettype none
`include "pdv_map.vh"
module pdv_video_in #(
  parameter COLS = `PDV_SCREEN_COLS, // screen width
  parameter ROWS = `PDV_SCREEN_ROWS, // screen height
  parameter GAP_LINES = `PDV_FRAME_GAP_LINES, // frame-start gap in lines
  parameter LINE_MAX = `PDV_LINE_MAX_STROBES // longest line in strobes
) (
  input wire sys_clk_i, // 125 MHz system clock
  input wire resetn_i, // async reset, active low
  input wire pixel_strobe_i, // pixel clock from source
  input wire pixel_valid_window_i, // data-enable from source
  input wire [`PDV_PIX_W-1:0] pixel_i, // rgb pixel word
  input wire lane_format_pin_i, // format strap level
  input wire depth_sel_i, // color depth strap level
  output reg [`PDV_PIX_W-1:0] out_pixel_o, // pixel to the screen
  output reg [`PDV_COL_W-1:0] out_col_o, // screen column
  output reg [`PDV_ROW_W-1:0] out_row_o, // screen row
  output reg out_valid_o, // one-cycle pixel write pulse
  output reg frame_start_o, // one-cycle top-of-frame pulse
  output reg primary_lane_arrangement_o, // latched format choice
  output reg depth_10bit_o // latched depth choice
);
  localparam [31:0] COLS_M1 = COLS - 1; // full-width final column
  localparam [31:0] ROWS_M1 = ROWS - 1; // full-width final row
  // gap counted in shortest legal lines; hblank stays far below one line
  localparam [31:0] GAP_FULL = GAP_LINES * `PDV_LINE_MIN_STROBES;
  localparam [`PDV_COL_W-1:0] LAST_COL = COLS_M1[`PDV_COL_W-1:0]; // final column
  localparam [`PDV_ROW_W-1:0] LAST_ROW = ROWS_M1[`PDV_ROW_W-1:0]; // final row
  // gap in strobes; hold the rise only once this much low time passed
  localparam [`PDV_GAP_CNT_W-1:0] GAP_STROBES = GAP_FULL[`PDV_GAP_CNT_W-1:0];
  localparam S_IDLE = 4'b0001; // waiting for frame start
  localparam S_ACTIVE = 4'b0010; // window high, taking pixels
  localparam S_HBLANK = 4'b0100; // window low within frame
  localparam S_FILL = 4'b1000; // padding black to end of row

  wire [`PDV_PIX_W+3:0] s_bus; // synchronised inputs
  wire s_strobe; // synced strobe
  wire s_win; // synced window
  wire [`PDV_PIX_W-1:0] s_pix; // synced pixel
  wire s_fmt; // synced format strap
  wire s_depth; // synced depth strap
  reg strobe_d; // previous strobe level
  reg [3:0] state; // one-hot fsm
  reg [3:0] next_state; // fsm next
  reg [`PDV_COL_W-1:0] col; // next column to write
  reg [`PDV_ROW_W-1:0] row; // current row
  reg [`PDV_GAP_CNT_W-1:0] gap_cnt; // strobes with window low
  reg straps_taken; // straps caught once after reset
  wire strobe_rise; // sampling edge of pixel clock
  wire gap_long; // low interval reached frame gap

  // one synchroniser for every outside level; pixel skew against the
  // strobe is covered because the strobe is slower than 2 sys cycles
  pdv_sync2 #(.W(`PDV_PIX_W + 4)) u_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .async_i({pixel_strobe_i, pixel_valid_window_i, lane_format_pin_i,
              depth_sel_i, pixel_i}),
    .sync_o(s_bus)
  );
  assign s_strobe = s_bus[`PDV_PIX_W+3];
  assign s_win = s_bus[`PDV_PIX_W+2];
  assign s_fmt = s_bus[`PDV_PIX_W+1];
  assign s_depth = s_bus[`PDV_PIX_W];
  assign s_pix = s_bus[`PDV_PIX_W-1:0];
  assign strobe_rise = s_strobe & ~strobe_d;
  assign gap_long = (gap_cnt >= GAP_STROBES);

  // edge finder on the synced strobe
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= s_strobe;
    end
  end

  // count low strobes; saturates so long gaps stay recognised
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_cnt <= {`PDV_GAP_CNT_W{1'b0}};
    end else if (strobe_rise) begin
      if (s_win) begin
        gap_cnt <= {`PDV_GAP_CNT_W{1'b0}};
      end else if (!gap_long) begin
        gap_cnt <= gap_cnt + 1'b1;
      end
    end
  end

  // straps caught after release, held; changing them live is not
  // supported since the source only changes them with power off
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      straps_taken <= 1'b0;
      primary_lane_arrangement_o <= 1'b1;
      depth_10bit_o <= 1'b0;
    end else if (!straps_taken && strobe_rise) begin
      straps_taken <= 1'b1;
      primary_lane_arrangement_o <= (s_fmt == `PDV_FMT_PRIMARY);
      depth_10bit_o <= (s_depth == `PDV_DEPTH_10BIT);
    end
  end

  // fsm next state
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (strobe_rise && s_win && gap_long) begin
          next_state = S_ACTIVE;
        end
      end
      S_ACTIVE: begin
        if (strobe_rise && !s_win) begin
          // nothing to pad after a full line or on a dropped row
          next_state = (col > LAST_COL || row > LAST_ROW) ? S_HBLANK : S_FILL;
        end
      end
      S_FILL: begin
        if (col == LAST_COL) begin
          next_state = S_HBLANK; // last black pixel goes out now
        end
      end
      S_HBLANK: begin
        if (strobe_rise && s_win) begin
          next_state = S_ACTIVE;
        end else if (gap_long) begin
          next_state = S_IDLE; // frame over, rows left are not written
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // pixel placement, black fill and row stepping
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= S_IDLE;
      col <= {`PDV_COL_W{1'b0}};
      row <= {`PDV_ROW_W{1'b0}};
      out_pixel_o <= `PDV_BLACK;
      out_col_o <= {`PDV_COL_W{1'b0}};
      out_row_o <= {`PDV_ROW_W{1'b0}};
      out_valid_o <= 1'b0;
      frame_start_o <= 1'b0;
    end else begin
      state <= next_state;
      out_valid_o <= 1'b0;
      frame_start_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (strobe_rise && s_win && gap_long) begin
            row <= {`PDV_ROW_W{1'b0}};
            frame_start_o <= 1'b1;
            out_pixel_o <= s_pix;
            out_col_o <= {`PDV_COL_W{1'b0}};
            out_row_o <= {`PDV_ROW_W{1'b0}};
            out_valid_o <= 1'b1;
            col <= {{(`PDV_COL_W-1){1'b0}}, 1'b1};
          end
        end
        S_ACTIVE: begin
          if (strobe_rise && s_win) begin
            // pixel word passed whole: 10 bit codes, rgb order
            out_pixel_o <= s_pix;
            out_col_o <= col;
            out_row_o <= row;
            out_valid_o <= (col <= LAST_COL) && (row <= LAST_ROW);
            if (col <= LAST_COL) begin
              col <= col + 1'b1; // extra pixels past width dropped
            end
          end
        end
        S_FILL: begin
          // one black pixel per sys cycle; a wide screen with a short
          // window needs a blanking long enough to finish the fill
          out_pixel_o <= `PDV_BLACK;
          out_col_o <= col;
          out_row_o <= row;
          out_valid_o <= 1'b1;
          col <= (col == LAST_COL) ? {`PDV_COL_W{1'b0}} : col + 1'b1;
        end
        S_HBLANK: begin
          if (strobe_rise && s_win) begin
            // new line: leftmost column, next row
            out_pixel_o <= s_pix;
            out_col_o <= {`PDV_COL_W{1'b0}};
            out_row_o <= row + 1'b1;
            out_valid_o <= (row < LAST_ROW);
            // row stops one past the end so later lines stay dropped
            row <= (row <= LAST_ROW) ? row + 1'b1 : row;
            col <= {{(`PDV_COL_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          col <= {`PDV_COL_W{1'b0}};
        end
      endcase
      // a full-width line leaves col past the end; wrap for next line
      if (state == S_ACTIVE && strobe_rise && !s_win && col > LAST_COL) begin
        col <= {`PDV_COL_W{1'b0}};
      end
    end
  end
endmodule // pdv_video_in
`default_nettype wire

// ---- dv/pdv_video_in_chk.sv ----
/* port checker for pdv_video_in.
   assumes it is bound to the design and sees its ports only. */
`default_nettype none
`include "pdv_map.vh"
module pdv_video_in_chk #(
  parameter COLS = 8, // screen width
  parameter ROWS = 4 // screen height
) (
  input wire logic sys_clk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic pixel_strobe_i, // source strobe
  input wire logic pixel_valid_window_i, // source window
  input wire logic [`PDV_PIX_W-1:0] pixel_i, // source pixel
  input wire logic lane_format_pin_i, // format strap
  input wire logic depth_sel_i, // depth strap
  input wire logic [`PDV_PIX_W-1:0] out_pixel_o, // written pixel
  input wire logic [`PDV_COL_W-1:0] out_col_o, // column
  input wire logic [`PDV_ROW_W-1:0] out_row_o, // row
  input wire logic out_valid_o, // write pulse
  input wire logic frame_start_o, // frame pulse
  input wire logic primary_lane_arrangement_o, // format
  input wire logic depth_10bit_o // depth
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // real pixels are a strobe apart, so back-to-back writes are fill
  sequence s_burst; out_valid_o && $past(out_valid_o); endsequence
  property p_fs_origin; frame_start_o |-> out_valid_o && out_col_o == 0 && out_row_o == 0;
  endproperty
  a_fs_origin: assert property (p_fs_origin) else $error("frame start off origin");
  property p_origin_fs; out_valid_o && out_col_o == 0 && out_row_o == 0 |-> frame_start_o;
  endproperty
  a_origin_fs: assert property (p_origin_fs) else $error("origin without start");
  property p_fs_pulse; frame_start_o |=> !frame_start_o; endproperty
  a_fs_pulse: assert property (p_fs_pulse) else $error("frame start too long");
  property p_bounds; out_valid_o |-> out_col_o < COLS && out_row_o < ROWS; endproperty
  a_bounds: assert property (p_bounds) else $error("write off screen");
  property p_col_step; s_burst |-> out_col_o == $past(out_col_o) + 1'b1 && $stable(out_row_o);
  endproperty
  a_col_step: assert property (p_col_step) else $error("fill column skipped");
  property p_fill_black; s_burst |-> out_pixel_o == `PDV_BLACK; endproperty
  a_fill_black: assert property (p_fill_black) else $error("fill not black");
  property p_straps;
    out_valid_o |-> primary_lane_arrangement_o == lane_format_pin_i &&
      depth_10bit_o == depth_sel_i;
  endproperty
  a_straps: assert property (p_straps) else $error("strap mismatch");
  c_frame: cover property (frame_start_o);
  c_fill: cover property (s_burst);
  c_last: cover property (out_valid_o && out_col_o == COLS - 1);
endmodule // pdv_video_in_chk
bind pdv_video_in pdv_video_in_chk #(.COLS(COLS), .ROWS(ROWS)) u_chk (.sys_clk_i, .resetn_i,
  .pixel_strobe_i, .pixel_valid_window_i, .pixel_i, .lane_format_pin_i, .depth_sel_i,
  .out_pixel_o, .out_col_o, .out_row_o, .out_valid_o, .frame_start_o,
  .primary_lane_arrangement_o, .depth_10bit_o);
`default_nettype wire

// ---- dv/pdv_src_model.sv ----
/* video source model: free strobe, window and pixel changed on its fall.
   assumes the bench calls idle and line one after another. */
`default_nettype none
module pdv_src_model (
  output var logic strobe_o, // pixel strobe, 64 ns
  output var logic win_o, // data-enable window
  output var logic [29:0] pix_o // pixel word
);
  timeunit 1ns;
  timeprecision 1ps;
  // strobe keeps running in blanking: the frame gap is counted in strobes
  initial begin
    strobe_o = 1'b0;
    win_o = 1'b0;
    pix_o = 30'h0;
    #3;
    // slowed strobe: the block only needs two sys cycles per period
    forever #32 strobe_o = ~strobe_o;
  end
  // blanking: data toggles so a stale word never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge strobe_o);
      win_o <= 1'b0;
      pix_o <= ~pix_o;
    end
  endtask
  // window high exactly while pixels are on the wire
  task automatic line(input logic [29:0] q[$]);
    foreach (q[i]) begin
      @(negedge strobe_o);
      win_o <= 1'b1;
      // links arrive merged here: one whole word per strobe
      pix_o <= q[i];
    end
  endtask
endmodule // pdv_src_model
`default_nettype wire

// ---- dv/tb_top.sv ----
/* bench for pdv_video_in: corner and random lines via the source model.
   assumes the model and the bound checker are compiled with it. */
`default_nettype none
`include "pdv_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int COLS = 8; // shrunk screen keeps the run short
  localparam int ROWS = 4;
  logic sys_clk_i, resetn_i, fmt, dep, strobe, win, out_valid, fs, fmt_o, dep_o;
  logic [`PDV_PIX_W-1:0] pix, out_pixel;
  logic [`PDV_COL_W-1:0] out_col;
  logic [`PDV_ROW_W-1:0] out_row;
  logic [51:0] expq[$]; // expected {start,row,col,pixel}
  logic [29:0] q[$]; // pixels of the next line
  int row, miscompares, checks, seed;
  pdv_src_model src (.strobe_o(strobe), .win_o(win), .pix_o(pix));
  pdv_video_in #(.COLS(COLS), .ROWS(ROWS), .GAP_LINES(1)) uut (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .pixel_strobe_i(strobe), .pixel_valid_window_i(win), .pixel_i(pix),
    .lane_format_pin_i(fmt), .depth_sel_i(dep), .out_pixel_o(out_pixel), .out_col_o(out_col),
    .out_row_o(out_row), .out_valid_o(out_valid), .frame_start_o(fs),
    .primary_lane_arrangement_o(fmt_o), .depth_10bit_o(dep_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string nm, input logic [51:0] e, input logic [51:0] g);
    checks++;
    if (e !== g) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // every write must match the next expected one
  always @(posedge sys_clk_i) begin
    if (out_valid === 1'b1 && expq.size() == 0) chk("stray write", 52'h0, 52'h1);
    else if (out_valid === 1'b1)
      chk("write", expq.pop_front(), {fs, out_row, out_col, out_pixel});
  end
  // expected write for column c of line r: pixel, or black past the window
  function automatic logic [51:0] exp_word(input int r, input int c);
    logic [29:0] p;
    p = (c < q.size()) ? q[c] : `PDV_BLACK;
    return {r == 0 && c == 0, 10'(r), 11'(c), p};
  endfunction
  // expected writes of one line: pixels, then black to the right edge
  task automatic go();
    for (int c = 0; c < COLS; c++)
      if (row < ROWS)
        expq.push_back(exp_word(row, c));
    row++;
    src.line(q);
    src.idle(70);
  endtask
  task automatic rnd(input int n);
    q = {};
    repeat (n) q.push_back(30'($urandom));
    go();
  endtask
  task automatic gap();
    // lines and frames shrink with the screen; gap is one shortest line
    src.idle(1035);
    row = 0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    resetn_i = 1'b0;
    seed = $urandom(66399);
    fmt = 1'($urandom);
    dep = 1'($urandom);
    repeat (5) @(posedge sys_clk_i);
    chk("reset outputs", 52'h4, 52'({fmt_o, dep_o, out_valid}));
    #1 resetn_i = 1'b1;
    q = '{30'h1, 30'h2};
    src.line(q); // no gap seen yet, so this line is ignored
    chk("straps", 52'({fmt, dep}), 52'({fmt_o, dep_o}));
    gap();
    q = '{30'h3FF00000, 30'h000FFC00, 30'h000003FF, 30'h3FFFFFFF, 30'h0, 30'h1, 30'h3FE00000,
      30'h20000000};
    go();
    rnd(3);
    rnd(1);
    rnd(COLS + 2);
    rnd(2);
    gap();
    repeat (3) rnd(1 + $urandom % (COLS + 2));
    gap();
    for (int i = 0; i < 100 && expq.size() != 0; i++) @(posedge sys_clk_i);
    chk("pending writes", 52'h0, 52'(expq.size()));
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
